// ===== timer_x_regs.svh
// register offsets, field positions and reset values of the interval/event timer channel
`ifndef TIMER_X_REGS_SVH
`define TIMER_X_REGS_SVH
`define TMR_COUNT_OFS 12'h000
`define TMR_MODE_OFS 12'h004
`define TMR_START_OFS 12'h008
`define TMR_PORT_OFS 12'h00C
`define TMR_STATUS_OFS 12'h010
`define TMR_SEL_OFS 12'h014
`define MODE_OP_LSB 0
`define MODE_OP_MSB 1
`define MODE_OPT_LSB 2
`define MODE_OPT_MSB 3
`define MODE_GLVL_BIT 4
`define MODE_EDGE_LSB 4
`define MODE_EDGE_MSB 5
`define MODE_CKS_LSB 6
`define MODE_CKS_MSB 7
`define SEL_FREE_BIT 1
`define MODE_SRC_LSB 6
`define MODE_SRC_MSB 7
`define SEL_EXTSRC_BIT 0
`define MODE_RST 8'h00
`define COUNT_RST 16'hFFFF
`define DIV8_LAST 3'h7
`define DIV32_LAST 5'h1F
`define SUB_DIV32_LAST 5'h1F
`endif

// ===== timer_x_pkg.sv
// types shared by the interval/event timer channel
`default_nettype none
package timer_x_pkg;
	typedef enum logic [1:0] {
		OP_TIMER = 2'h0,
		OP_EVENT = 2'h1
	} op_mode_e;
	typedef enum logic [1:0] {
		PIN_PORT = 2'h0,
		PIN_PULSE = 2'h1,
		PIN_GATE = 2'h2,
		PIN_SRC = 2'h3
	} pin_fn_e;
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2
	} edge_sel_e;
	typedef enum logic [2:0] {
		APB_IDLE = 3'b001,
		APB_SETUP = 3'b010,
		APB_ACCESS = 3'b100
	} apb_state_e;
endpackage : timer_x_pkg
`default_nettype wire

// ===== pin_sync.sv
// two-stage synchroniser with edge detection on the settled level
`default_nettype none
module pin_sync
	import timer_x_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} sync_s;
	sync_s state_ff;
	sync_s nxt_state;
	always_comb begin
		nxt_state = state_ff;
		nxt_state.meta = async_in;
		nxt_state.sync = state_ff.meta;
		nxt_state.prev = state_ff.sync;
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign level_out = state_ff.sync;
	assign rise_out = state_ff.sync & ~state_ff.prev;
	assign fall_out = ~state_ff.sync & state_ff.prev;
endmodule : pin_sync
`default_nettype wire

// ===== prescaler.sv
// internal count source dividers: system clock, /8, /32 and subclock /32
`default_nettype none
`include "timer_x_regs.svh"
module prescaler
	import timer_x_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic subclk_tick_in,
	input wire logic [1:0] sel_in,
	output logic tick_out
);
	typedef struct packed {
		logic [2:0] div8;
		logic [4:0] div32;
		logic [4:0] sub32;
	} pre_s;
	pre_s state_ff;
	pre_s nxt_state;
	logic t8;
	logic t32;
	logic tsub;
	always_comb begin
		nxt_state = state_ff;
		nxt_state.div8 = state_ff.div8 + 3'h1;
		nxt_state.div32 = state_ff.div32 + 5'h01;
		if (subclk_tick_in) begin
			nxt_state.sub32 = state_ff.sub32 + 5'h01;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign t8 = (state_ff.div8 == `DIV8_LAST);
	assign t32 = (state_ff.div32 == `DIV32_LAST);
	assign tsub = subclk_tick_in && (state_ff.sub32 == `SUB_DIV32_LAST);
	always_comb begin
		case (sel_in)
			2'h0: tick_out = 1'b1;
			2'h1: tick_out = t8;
			2'h2: tick_out = t32;
			2'h3: tick_out = tsub;
			default: tick_out = 1'b0;
		endcase
	end
endmodule : prescaler
`default_nettype wire

// ===== timer_x_channel.sv
// interval timer / event counter channel with APB register access
// Operation
// - interval mode counts one of four software-selected prescaled internal clocks.
// - counter counts down; on underflow reloads from reload register, keeps counting.
// - value n gives one underflow every n+1 counted events.
// - counting runs while start flag is 1, halts when cleared to 0.
// - every underflow raises the interrupt request in both modes.
// - reading count register returns the present counter value.
// - write while stopped loads both reload register and counter.
// - write while counting loads reload register only, used at next reload.
// - gate option lets pin level enable or suspend counting.
// - pulse output option inverts pin output at every underflow.
// - interval mode pin is port, gate input or pulse output.
// - event mode may count pin edges, edge chosen by software.
// - event mode may count other timers' overflows, source chosen by software.
// - free-run option in event mode wraps without reloading at underflow.
// - event mode pin is port, count source input or pulse output.
// - two lowest mode register bits select the operating mode.
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none
`include "timer_x_regs.svh"
module timer_x_channel
	import timer_x_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic subclk_tick_in,
	input wire logic second_b_timer_ovf_in,
	input wire logic first_a_timer_ovf_in,
	input wire logic other_x_timer_ovf_in,
	input wire logic channel_io_pin_in,
	output logic channel_io_pin_out,
	output logic channel_io_pin_oe_out,
	output logic irq_out,
	output logic underflow_out
);
	typedef struct packed {
		logic [15:0] counter;
		logic [15:0] reload;
		logic [7:0] mode;
		logic start;
		logic port_dir;
		logic port_data;
		logic pulse;
		logic irq;
		logic ext_src;
		logic free_run;
		logic [31:0] rdata;
	} chan_s;
	chan_s state_ff;
	chan_s nxt_state;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;
	logic int_tick;
	op_mode_e op;
	pin_fn_e pin_fn;
	edge_sel_e edge_sel;
	logic pin_edge;
	logic ovf_src;
	logic src_evt;
	logic gate_ok;
	logic count_evt;
	logic underflow;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	pin_sync u_pin_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.async_in(channel_io_pin_in),
		.level_out(pin_level),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);
	prescaler u_prescaler (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.subclk_tick_in(subclk_tick_in),
		.sel_in(state_ff.mode[`MODE_CKS_MSB:`MODE_CKS_LSB]),
		.tick_out(int_tick)
	);
	assign op = op_mode_e'(state_ff.mode[`MODE_OP_MSB:`MODE_OP_LSB]);
	assign pin_fn = pin_fn_e'(state_ff.mode[`MODE_OPT_MSB:`MODE_OPT_LSB]);
	assign edge_sel = edge_sel_e'(state_ff.mode[`MODE_EDGE_MSB:`MODE_EDGE_LSB]);
	always_comb begin
		case (edge_sel)
			EDGE_FALL: pin_edge = pin_fall;
			EDGE_RISE: pin_edge = pin_rise;
			EDGE_BOTH: pin_edge = pin_rise | pin_fall;
			default: pin_edge = 1'b0;
		endcase
	end
	always_comb begin
		case (state_ff.mode[`MODE_SRC_MSB:`MODE_SRC_LSB])
			2'h0: ovf_src = second_b_timer_ovf_in;
			2'h1: ovf_src = first_a_timer_ovf_in;
			2'h2: ovf_src = other_x_timer_ovf_in;
			default: ovf_src = 1'b0;
		endcase
	end
	always_comb begin
		gate_ok = 1'b1;
		src_evt = 1'b0;
		case (op)
			OP_TIMER: begin
				src_evt = int_tick;
				if (pin_fn == PIN_GATE) begin
					gate_ok = (pin_level == state_ff.mode[`MODE_GLVL_BIT]);
				end
			end
			OP_EVENT: begin
				// edge counting only when the pin is assigned as count input
				if (state_ff.ext_src) begin
					src_evt = (pin_fn == PIN_SRC) & pin_edge;
				end else begin
					src_evt = ovf_src;
				end
			end
			default: begin
				src_evt = 1'b0;
			end
		endcase
	end
	assign count_evt = state_ff.start & gate_ok & src_evt;
	assign underflow = count_evt & (state_ff.counter == 16'h0000);
	assign addr_ok = (paddr == `TMR_COUNT_OFS) || (paddr == `TMR_MODE_OFS) ||
		(paddr == `TMR_START_OFS) || (paddr == `TMR_PORT_OFS) ||
		(paddr == `TMR_STATUS_OFS) || (paddr == `TMR_SEL_OFS);
	assign wr_acc = psel & penable & pwrite & addr_ok;
	assign rd_acc = psel & ~penable & ~pwrite;
	always_comb begin
		nxt_state = state_ff;
		if (count_evt) begin
			if (underflow) begin
				if ((op == OP_EVENT) && state_ff.free_run) begin
					nxt_state.counter = 16'hFFFF;
				end else begin
					nxt_state.counter = state_ff.reload;
				end
			end else begin
				nxt_state.counter = state_ff.counter - 16'h0001;
			end
		end
		if (underflow && (pin_fn == PIN_PULSE)) begin
			nxt_state.pulse = ~state_ff.pulse;
		end
		if (wr_acc) begin
			case (paddr)
				`TMR_COUNT_OFS: begin
					nxt_state.reload = pwdata[15:0];
					if (!state_ff.start) begin
						nxt_state.counter = pwdata[15:0];
					end
				end
				`TMR_MODE_OFS: nxt_state.mode = pwdata[7:0];
				`TMR_START_OFS: nxt_state.start = pwdata[0];
				`TMR_PORT_OFS: begin
					nxt_state.port_data = pwdata[0];
					nxt_state.port_dir = pwdata[1];
				end
				`TMR_STATUS_OFS: begin
					if (pwdata[0]) begin
						nxt_state.irq = 1'b0;
					end
				end
				`TMR_SEL_OFS: begin
					nxt_state.ext_src = pwdata[`SEL_EXTSRC_BIT];
					nxt_state.free_run = pwdata[`SEL_FREE_BIT];
				end
				default: nxt_state.mode = state_ff.mode;
			endcase
		end
		// a new underflow wins over a clear in the same cycle
		if (underflow) begin
			nxt_state.irq = 1'b1;
		end
		if (rd_acc) begin
			case (paddr)
				`TMR_COUNT_OFS: nxt_state.rdata = {16'h0000, state_ff.counter};
				`TMR_MODE_OFS: nxt_state.rdata = {24'h000000, state_ff.mode};
				`TMR_START_OFS: nxt_state.rdata = {31'h00000000, state_ff.start};
				`TMR_PORT_OFS: nxt_state.rdata = {29'h00000000, pin_level,
					state_ff.port_dir, state_ff.port_data};
				`TMR_STATUS_OFS: nxt_state.rdata = {30'h00000000, state_ff.pulse,
					state_ff.irq};
				`TMR_SEL_OFS: nxt_state.rdata = {30'h00000000, state_ff.free_run, state_ff.ext_src};
				default: nxt_state.rdata = 32'h00000000;
			endcase
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_ff.counter <= `COUNT_RST;
			state_ff.reload <= `COUNT_RST;
			state_ff.mode <= `MODE_RST;
			state_ff.start <= 1'b0;
			state_ff.port_dir <= 1'b0;
			state_ff.port_data <= 1'b0;
			state_ff.pulse <= 1'b0;
			state_ff.irq <= 1'b0;
			state_ff.ext_src <= 1'b0;
			state_ff.free_run <= 1'b0;
			state_ff.rdata <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// single wait-free access phase; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = state_ff.rdata;
	assign irq_out = state_ff.irq;
	assign underflow_out = underflow;
	always_comb begin
		case (pin_fn)
			PIN_PULSE: begin
				channel_io_pin_out = state_ff.pulse;
				channel_io_pin_oe_out = 1'b1;
			end
			PIN_PORT: begin
				channel_io_pin_out = state_ff.port_data;
				channel_io_pin_oe_out = state_ff.port_dir;
			end
			default: begin
				channel_io_pin_out = 1'b0;
				channel_io_pin_oe_out = 1'b0;
			end
		endcase
	end
	AST_RELOAD: assert property (@(posedge core_clk_in) disable iff (rst_in)
		underflow && !(op == OP_EVENT && state_ff.free_run) && !wr_acc
		|=> state_ff.counter == $past(state_ff.reload))
		else $error("counter did not reload on underflow");
	AST_DOWN: assert property (@(posedge core_clk_in) disable iff (rst_in)
		count_evt && !underflow && !wr_acc |=> state_ff.counter == $past(state_ff.counter) - 16'h0001)
		else $error("counter did not step down");
	AST_HALT: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!state_ff.start && !wr_acc |=> $stable(state_ff.counter))
		else $error("counter moved while stopped");
	AST_IRQ: assert property (@(posedge core_clk_in) disable iff (rst_in)
		underflow |=> irq_out)
		else $error("underflow did not raise interrupt");
	AST_WR_STOP: assert property (@(posedge core_clk_in) disable iff (rst_in)
		wr_acc && paddr == `TMR_COUNT_OFS && !state_ff.start
		|=> state_ff.counter == $past(pwdata[15:0]) && state_ff.reload == $past(pwdata[15:0]))
		else $error("stopped write did not load counter");
	AST_WR_RUN: assert property (@(posedge core_clk_in) disable iff (rst_in)
		wr_acc && paddr == `TMR_COUNT_OFS && state_ff.start && !count_evt
		|=> $stable(state_ff.counter))
		else $error("running write touched counter");
	AST_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_TIMER && pin_fn == PIN_GATE && pin_level != state_ff.mode[`MODE_GLVL_BIT]
		|-> !count_evt)
		else $error("counted with gate closed");
	AST_TOGGLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		underflow && pin_fn == PIN_PULSE |=> state_ff.pulse != $past(state_ff.pulse))
		else $error("pulse output did not toggle");
	AST_FREE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		underflow && op == OP_EVENT && state_ff.free_run && !wr_acc
		|=> state_ff.counter == 16'hFFFF)
		else $error("free-run counter did not wrap");
	// count sources, pin functions and register access
	AST_SRC_TIMER: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_TIMER && state_ff.start && pin_fn != PIN_GATE
		|-> count_evt == int_tick)
		else $error("timer mode ignored its prescaled source");
	AST_READ: assert property (@(posedge core_clk_in) disable iff (rst_in)
		rd_acc && paddr == `TMR_COUNT_OFS
		|=> prdata == {16'h0000, $past(state_ff.counter)})
		else $error("count read did not return the counter");
	AST_WR_RUN_RELOAD: assert property (@(posedge core_clk_in) disable iff (rst_in)
		wr_acc && paddr == `TMR_COUNT_OFS && state_ff.start
		|=> state_ff.reload == $past(pwdata[15:0]))
		else $error("running write missed the reload register");
	AST_PIN_PULSE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		pin_fn == PIN_PULSE
		|-> channel_io_pin_oe_out && channel_io_pin_out == state_ff.pulse)
		else $error("pulse level not driven on the pin");
	AST_PIN_PORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
		pin_fn == PIN_PORT |-> channel_io_pin_oe_out == state_ff.port_dir
		&& channel_io_pin_out == state_ff.port_data)
		else $error("port function not on the pin");
	AST_PIN_INPUT: assert property (@(posedge core_clk_in) disable iff (rst_in)
		pin_fn == PIN_GATE || pin_fn == PIN_SRC
		|-> !channel_io_pin_oe_out)
		else $error("pin driven while used as an input");
	AST_EDGE_RISE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_EVENT && state_ff.ext_src && pin_fn == PIN_SRC && state_ff.start
		&& edge_sel == EDGE_RISE |-> count_evt == $rose(pin_level))
		else $error("rising pin edge not counted");
	AST_EDGE_FALL: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_EVENT && state_ff.ext_src && pin_fn == PIN_SRC && state_ff.start
		&& edge_sel == EDGE_FALL |-> count_evt == $fell(pin_level))
		else $error("falling pin edge not counted");
	AST_OVF_A: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_EVENT && !state_ff.ext_src && state_ff.start &&
		state_ff.mode[`MODE_SRC_MSB:`MODE_SRC_LSB] == 2'h1 |-> count_evt == first_a_timer_ovf_in)
		else $error("first timer overflow not counted");
	AST_OVF_B: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_EVENT && !state_ff.ext_src && state_ff.start &&
		state_ff.mode[`MODE_SRC_MSB:`MODE_SRC_LSB] == 2'h0 |-> count_evt == second_b_timer_ovf_in)
		else $error("second timer overflow not counted");
	AST_NO_PIN_EVT: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_EVENT && state_ff.ext_src && pin_fn != PIN_SRC
		|-> !count_evt)
		else $error("pin edges counted without the count input function");
	AST_MODE_IDLE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op != OP_TIMER && op != OP_EVENT
		|-> !count_evt)
		else $error("undefined operating mode counted");
	AST_SYNC: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!$past(rst_in) && !$past(rst_in, 2)
		|-> pin_level == $past(channel_io_pin_in, 2))
		else $error("pin level not two stages behind the pin");
	AST_GATE_OPEN: assert property (@(posedge core_clk_in) disable iff (rst_in)
		op == OP_TIMER && pin_fn == PIN_GATE && state_ff.start
		&& pin_level == state_ff.mode[`MODE_GLVL_BIT] |-> count_evt == int_tick)
		else $error("open gate did not pass the count source");
	AST_IRQ_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
		irq_out && !(wr_acc && paddr == `TMR_STATUS_OFS && pwdata[0])
		|=> irq_out)
		else $error("interrupt request dropped without a clear");
	AST_START: assert property (@(posedge core_clk_in) disable iff (rst_in)
		wr_acc && paddr == `TMR_START_OFS
		|=> state_ff.start == $past(pwdata[0]))
		else $error("start flag write lost");
	AST_PULSE_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!underflow
		|=> $stable(state_ff.pulse))
		else $error("pulse level moved without an underflow");
	AST_RDATA_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!rd_acc
		|=> $stable(prdata))
		else $error("read data changed outside a read setup");
endmodule : timer_x_channel
`default_nettype wire

// ===== pin_partner.sv
// far-side model: pin driver and overflow pulses of neighbouring timers
`default_nettype none
module pin_partner (
	input wire logic core_clk_in,
	input wire logic drv_level_in,
	input wire logic [2:0] ovf_req_in,
	input wire logic pin_drive_in,
	input wire logic pin_oe_in,
	output logic pin_level_out,
	output logic [2:0] ovf_out = 3'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// the channel owns the wire while it drives it
	assign pin_level_out = pin_oe_in ? pin_drive_in : drv_level_in;
	// one-cycle overflow pulses in the channel's own clock domain
	always @(posedge core_clk_in) begin
		ovf_out <= ovf_req_in;
	end
endmodule : pin_partner
`default_nettype wire

// ===== timer_x_interval_event_counter_tb.sv
// self-checking bench for the interval/event timer channel
`default_nettype none
`include "timer_x_regs.svh"
module timer_x_interval_event_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pin_out, pin_oe, irq, uf, pin_lvl;
	logic subclk = 1'b0;
	logic drv = 1'b0;
	logic [2:0] ovf_req = 3'h0;
	logic [2:0] ovf;
	logic [31:0] seed = 32'h738C;
	int errors = 0;
	int compares = 0;
	int gap = 0;
	int gaps[$];
	timer_x_channel timer_x_channel_inst (
		.core_clk_in(core_clk), .rst_in(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .subclk_tick_in(subclk), .second_b_timer_ovf_in(ovf[0]),
		.first_a_timer_ovf_in(ovf[1]), .other_x_timer_ovf_in(ovf[2]),
		.channel_io_pin_in(pin_lvl), .channel_io_pin_out(pin_out),
		.channel_io_pin_oe_out(pin_oe), .irq_out(irq), .underflow_out(uf)
	);
	pin_partner pin_partner_inst (
		.core_clk_in(core_clk), .drv_level_in(drv), .ovf_req_in(ovf_req),
		.pin_drive_in(pin_out), .pin_oe_in(pin_oe), .pin_level_out(pin_lvl), .ovf_out(ovf)
	);
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// subclock ticks every second cycle, so its /32 source spans 64 cycles
	always @(posedge core_clk) subclk <= ~subclk;
	always @(negedge core_clk) begin
		gap++;
		if (uf === 1'b1) begin
			gaps.push_back(gap);
			gap = 0;
		end
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] mdl(input int n, input int k, input bit free);
		if (free) return 32'((n - k) & 32'hFFFF);
		return 32'(n - k % (n + 1));
	endfunction : mdl
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 50) errors++;
		@(posedge core_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd
	// stopped write loads the counter too, so each run starts from n
	task automatic arm(input logic [7:0] md, input logic [1:0] sel, input logic [15:0] n);
		wr(`TMR_START_OFS, 32'h0);
		wr(`TMR_MODE_OFS, {24'h0, md});
		wr(`TMR_SEL_OFS, {30'h0, sel});
		wr(`TMR_COUNT_OFS, {16'h0, n});
		wr(`TMR_START_OFS, 32'h1);
	endtask : arm
	task automatic sync_uf();
		int t;
		t = 0;
		gaps.delete();
		while (gaps.size() == 0 && t < 3000) begin
			@(posedge core_clk);
			t++;
		end
		if (t >= 3000) errors++;
	endtask : sync_uf
	task automatic complete_run();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		complete_run();
	end
	initial begin
		logic [31:0] a, b;
		logic e;
		int n, k, cnt;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(`TMR_COUNT_OFS, a);
		check(a, 32'hFFFF);
		apb(1'b0, 12'h020, 32'h0, a, e);
		check({31'h0, e}, 32'h1);
		for (int s = 0; s < 4; s++) begin
			n = 2 + rnd() % 5;
			arm({2'(s), 6'h00}, 2'h0, 16'(n));
			sync_uf();
			sync_uf();
			cnt = s == 0 ? 1 : s == 1 ? 8 : s == 2 ? 32 : 64;
			check(32'(gaps[0]), 32'((n + 1) * cnt));
		end
		arm(8'h00, 2'h0, 16'h0014);
		sync_uf();
		wr(`TMR_COUNT_OFS, 32'h5);
		gaps.delete();
		cyc(40);
		check(32'(gaps[0]), 32'h15);
		check(32'(gaps[1]), 32'h6);
		wr(`TMR_START_OFS, 32'h0);
		check({31'h0, irq}, 32'h1);
		wr(`TMR_STATUS_OFS, 32'h1);
		check({31'h0, irq}, 32'h0);
		wr(`TMR_COUNT_OFS, 32'h1234);
		rd(`TMR_COUNT_OFS, a);
		cyc(5);
		rd(`TMR_COUNT_OFS, b);
		check(a, 32'h1234);
		check(b, 32'h1234);
		arm(8'h04, 2'h0, 16'h0003);
		sync_uf();
		cyc(1);
		a[0] = pin_out;
		sync_uf();
		cyc(1);
		check({30'h0, pin_oe, pin_out}, {30'h0, 1'b1, ~a[0]});
		for (int g = 0; g < 2; g++) begin
			for (int l = 0; l < 2; l++) begin
				drv <= l[0];
				arm({3'h0, g[0], 4'h8}, 2'h0, 16'h0FFF);
				rd(`TMR_COUNT_OFS, a);
				cyc(4);
				rd(`TMR_COUNT_OFS, b);
				check({30'h0, pin_oe, a != b}, {30'h0, 1'b0, l == g});
			end
		end
		for (int ed = 0; ed < 3; ed++) begin
			drv <= 1'b0;
			k = 3 + rnd() % 4;
			arm({2'h0, 2'(ed), 4'hD}, 2'h1, 16'h0009);
			for (int i = 0; i < k; i++) begin
				drv <= ~drv;
				cyc(6);
			end
			cnt = ed == 2 ? k : ed == 1 ? (k + 1) / 2 : k / 2;
			rd(`TMR_COUNT_OFS, a);
			check(a, mdl(9, cnt, 1'b0));
		end
		wr(`TMR_START_OFS, 32'h0);
		wr(`TMR_STATUS_OFS, 32'h1);
		// the last pulse goes to a source that is not selected
		for (int s = 0; s < 3; s++) begin
			k = 4 + rnd() % 4;
			arm({2'(s), 6'h01}, {s == 2, 1'b0}, 16'h0002);
			for (int i = 0; i <= k; i++) begin
				ovf_req <= (i == k) ? 3'h1 << ((s + 1) % 3) : 3'h1 << s;
				@(posedge core_clk);
				ovf_req <= 3'h0;
				cyc(2);
			end
			rd(`TMR_COUNT_OFS, a);
			check(a, mdl(2, k, s == 2));
		end
		check({31'h0, irq}, 32'h1);
		// port function under an undefined operating mode that must hold the count
		arm(8'h02, 2'h0, 16'h0010);
		wr(`TMR_PORT_OFS, 32'h3);
		check({30'h0, pin_oe, pin_out}, 32'h3);
		cyc(2);
		rd(`TMR_PORT_OFS, a);
		check(a, 32'h7);
		rd(`TMR_COUNT_OFS, b);
		check(b, 32'h10);
		wr(`TMR_PORT_OFS, 32'h0);
		check({30'h0, pin_oe, pin_out}, 32'h0);
		complete_run();
	end
endmodule : timer_x_interval_event_counter_tb
`default_nettype wire
